/* File: core/see_fifo.sv */
`timescale 1ns/10ps
// write buffer between the bus engine and the array; depth a power of two
module see_fifo
    import see_pkg::*;
#(
    parameter int unsigned WIDTH = SEE_WORD_W,
    parameter int unsigned DEPTH = SEE_FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes; pop refills the output register whenever it frees up
    assign in_ready = (count != CW'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = (count != '0) && (!out_valid || out_ready);
    assign level = count;

    // storage has no reset, only the pointers and count need one
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wptr] <= in_data;
        end
    end

    // pointers wrap naturally because depth is a power of two
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr <= wptr + 1'b1;
            end
            if (pop)
            begin
                rptr <= rptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end

    // registered read data
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data <= mem[rptr];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end

endmodule : see_fifo

/* File: core/see_frontend.sv */
`timescale 1ns/10ps
// What this block does
// - compare select bits b3,b2 against the two chip-select strap inputs
// - unconnected strap inputs count as zero when matching
// - write-inhibit high blocks all array writes; low or floating allows
// - under write-inhibit, ack select and address, never ack data bytes
// - serial clock samples incoming bits and times outgoing bits
// - data line only pulled low or released, never driven high
// - ignore the bus until the power-on threshold is crossed
// - crossing the power-on threshold resets state and enters standby
// - supply below threshold stops all responses
// - a stop enters standby unless a write cycle runs
// - array is 128 K locations of 8 bits, 17 address bits
// - optional 256-byte id page, read only once locked
// - select byte msb first: type, strap, top address bit, read/write
// - matching select acked in ninth clock; mismatch releases to standby
// - stop right after a data ack starts the write; elsewhere not
// - during the write cycle the data line is off, no response
module see_frontend
    import see_pkg::*;
#(
    parameter bit HAS_ID_PAGE = 1'b1,
    parameter int unsigned FIFO_DEPTH = SEE_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic por_ok,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select_strap_low,
    input wire logic chip_select_strap_high,
    input wire logic write_inhibit_input,
    input wire logic id_page_locked,
    input wire logic array_busy,
    input wire logic [SEE_DATA_W-1:0] rd_data,
    output logic rd_req,
    output logic rd_id,
    output logic [SEE_ADDR_W-1:0] rd_addr,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [SEE_KIND_W-1:0] wr_kind,
    output logic wr_id,
    output logic [SEE_ADDR_W-1:0] wr_addr,
    output logic [SEE_DATA_W-1:0] wr_data,
    output logic standby,
    output logic write_cycle
);

    localparam int unsigned NSYNC = 6;
    localparam int unsigned LW = $clog2(FIFO_DEPTH+1);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // true when the select byte addresses this device
    function automatic logic select_match(
        input logic [SEE_DATA_W-1:0] sel,
        input logic [1:0] strap,
        input logic has_id
    );
        logic [3:0] kind;
        kind = sel[SEE_SEL_TYPE_HI:SEE_SEL_TYPE_LO];
        select_match = ((kind == SEE_TYPE_ARRAY) ||
                        (has_id && (kind == SEE_TYPE_IDPAGE))) &&
                       (sel[SEE_SEL_STRAP_HI:SEE_SEL_STRAP_LO] == strap);
    endfunction : select_match

    // next address; inside a page only the low byte counts and rolls over
    function automatic logic [SEE_ADDR_W-1:0] next_addr(
        input logic [SEE_ADDR_W-1:0] cur,
        input logic in_page
    );
        logic [SEE_ADDR_W-1:0] inc;
        inc = cur + 1'b1;
        if (in_page)
        begin
            next_addr = {cur[SEE_ADDR_W-1:SEE_PAGE_BITS],
                         inc[SEE_PAGE_BITS-1:0]};
        end
        else
        begin
            next_addr = inc;
        end
    endfunction : next_addr

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; pins are asynchronous to core_clk
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic por_s;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;
    logic inhibit_s;
    logic scl_prev;
    logic sda_prev;

    // the serial clock is oversampled here; its period is several core_clk
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= {por_ok, scl_in, sda_in, chip_select_strap_high,
                      chip_select_strap_low, write_inhibit_input};
            sync2 <= sync1;
        end
    end

    assign por_s = sync2[5];
    assign scl_s = sync2[4];
    assign sda_s = sync2[3];
    assign strap_s = sync2[2:1];    // a floating strap reads as zero
    assign inhibit_s = sync2[0];    // floating means low, writes allowed

    // previous levels for edge and condition detection
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // bits move on clock edges, start and stop are data edges with clock high
    assign scl_rise = scl_s && !scl_prev;   // sample point
    assign scl_fall = !scl_s && scl_prev;   // drive point
    assign start_det = scl_s && scl_prev && sda_prev && !sda_s;
    assign stop_det = scl_s && scl_prev && !sda_prev && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // write buffer toward the array
    logic push_valid;
    logic [SEE_WORD_W-1:0] push_word;
    logic push_ready;
    logic [LW-1:0] level;
    logic [SEE_WORD_W-1:0] pop_word;
    logic room;

    see_fifo #(
        .WIDTH(SEE_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .srst(srst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(pop_word),
        .level(level)
    );

    assign wr_kind = pop_word[SEE_WORD_W-1 -: SEE_KIND_W];
    assign wr_id = pop_word[SEE_ADDR_W+SEE_DATA_W];
    assign wr_addr = pop_word[SEE_DATA_W +: SEE_ADDR_W];
    assign wr_data = pop_word[SEE_DATA_W-1:0];
    // a full buffer makes data bytes go unacked, so the master backs off
    assign room = push_ready && (level <= LW'(FIFO_DEPTH - SEE_FIFO_SPARE));

    ////////////////////////////////////////////////////////////////////////
    // protocol engine
    see_state_e state;
    logic [3:0] bit_cnt;
    logic [SEE_DATA_W-1:0] shift;
    logic [SEE_DATA_W-1:0] tx;
    logic [SEE_ADDR_W-1:0] addr;
    logic ack_slot;
    logic ack_done;
    logic byte_acked;
    logic data_done;
    logic pending;
    logic is_id;
    logic stop_commit;
    logic accept;

    // commit only when the stop falls in the slot after a data ack
    assign stop_commit = stop_det && (state == ST_WRITE) && data_done &&
                         !write_cycle && (state != ST_OFF);
    // a data byte is taken only when writes are allowed and room exists
    assign accept = !inhibit_s && room &&
                    !(is_id && id_page_locked);

    // one flat process keeps bit timing and byte decisions in step
    always_ff @(posedge core_clk)
    begin
        push_valid <= 1'b0;
        rd_req <= 1'b0;
        if (srst || !por_s)
        begin
            state <= ST_OFF;                    // deaf below threshold
            bit_cnt <= '0;
            shift <= '0;
            tx <= '0;
            addr <= '0;
            ack_slot <= 1'b0;
            ack_done <= 1'b0;
            byte_acked <= 1'b0;
            data_done <= 1'b0;
            pending <= 1'b0;
            is_id <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;                    // only ever pulls low
            push_word <= '0;
            rd_id <= 1'b0;
            rd_addr <= '0;
        end
        else if (state == ST_OFF)
        begin
            state <= ST_STANDBY;                // fresh state, standby
        end
        else if (write_cycle)
        begin
            sda_oe <= 1'b0;                     // line off, no reply
            state <= ST_STANDBY;
        end
        else if (start_det || stop_det)
        begin
            sda_oe <= 1'b0;
            bit_cnt <= '0;
            ack_slot <= 1'b0;
            ack_done <= 1'b0;
            data_done <= 1'b0;
            if (pending)
            begin
                // queued bytes are either committed or thrown away
                push_valid <= 1'b1;
                push_word <= {stop_commit ? SEE_KIND_COMMIT : SEE_KIND_DISCARD,
                              is_id, addr, shift};
                pending <= 1'b0;
            end
            state <= start_det ? ST_SELECT : ST_STANDBY;
        end
        else if (state != ST_STANDBY && state != ST_IGNORE && scl_rise)
        begin
            if (ack_slot)
            begin
                // ninth clock: a master noack ends a read
                if (state == ST_READ && sda_s)
                begin
                    state <= ST_IGNORE;
                end
                ack_done <= 1'b1;
                bit_cnt <= '0;
            end
            else if (bit_cnt != SEE_BITS_PER_BYTE)
            begin
                shift <= {shift[SEE_DATA_W-2:0], sda_s};    // msb first
                bit_cnt <= bit_cnt + 1'b1;
                data_done <= data_done && (bit_cnt == '0); // stop rise
            end
        end
        else if (state != ST_STANDBY && state != ST_IGNORE && scl_fall)
        begin
            if (ack_done)
            begin
                // end of the ack slot: release, or put out the next read bit
                ack_done <= 1'b0;
                ack_slot <= 1'b0;
                data_done <= byte_acked;
                byte_acked <= 1'b0;
                sda_oe <= 1'b0;
                if (state == ST_READ)
                begin
                    sda_oe <= !rd_data[SEE_DATA_W-1];
                    tx <= {rd_data[SEE_DATA_W-2:0], 1'b0};
                    addr <= next_addr(addr, is_id);
                end
            end
            else if (bit_cnt == SEE_BITS_PER_BYTE && !ack_slot)
            begin
                ack_slot <= 1'b1;
                sda_oe <= 1'b0;
                case (state)
                    ST_SELECT:
                    begin
                        if (select_match(shift, strap_s, HAS_ID_PAGE))
                        begin
                            sda_oe <= 1'b1;     // ack in ninth clock
                            is_id <= (shift[SEE_SEL_TYPE_HI:SEE_SEL_TYPE_LO]
                                      == SEE_TYPE_IDPAGE);
                            if (shift[SEE_SEL_TYPE_HI:SEE_SEL_TYPE_LO]
                                == SEE_TYPE_ARRAY)
                            begin
                                // top of the 17-bit address
                                addr[SEE_TOP_ADDR_POS] <=
                                    shift[SEE_SEL_TOP_ADDR];
                            end
                            if (shift[SEE_SEL_RW])
                            begin
                                state <= ST_READ;
                                rd_req <= 1'b1;
                                rd_addr <= addr;
                                rd_id <= (shift[SEE_SEL_TYPE_HI:
                                                SEE_SEL_TYPE_LO]
                                          == SEE_TYPE_IDPAGE);
                            end
                            else
                            begin
                                state <= ST_ADDR_HI;
                            end
                        end
                        else
                        begin
                            ack_slot <= 1'b0;
                            state <= ST_STANDBY;        // deselect
                        end
                    end
                    ST_ADDR_HI:
                    begin
                        addr[SEE_ADDR_W-2:SEE_DATA_W] <= shift;
                        sda_oe <= 1'b1;     // acked even when inhibited
                        state <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO:
                    begin
                        addr[SEE_DATA_W-1:0] <= shift;
                        sda_oe <= 1'b1;     // acked even when inhibited
                        state <= ST_WRITE;
                    end
                    ST_WRITE:
                    begin
                        if (accept)
                        begin
                            sda_oe <= 1'b1;
                            byte_acked <= 1'b1;
                            pending <= 1'b1;
                            push_valid <= 1'b1;
                            push_word <= {SEE_KIND_DATA, is_id, addr, shift};
                            addr <= next_addr(addr, 1'b1);  // page rollover
                        end
                        // otherwise noack and nothing queued
                    end
                    ST_READ:
                    begin
                        // master owns the ack; fetch the following byte
                        rd_req <= 1'b1;
                        rd_addr <= addr;
                        rd_id <= is_id;
                    end
                    default:
                    begin
                        ack_slot <= 1'b0;
                    end
                endcase
            end
            else if (state == ST_READ && !ack_slot)
            begin
                sda_oe <= !tx[SEE_DATA_W-1];
                tx <= {tx[SEE_DATA_W-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal write cycle: from the committing stop until the array is idle
    // the array must raise array_busy when it takes the commit word
    always_ff @(posedge core_clk)
    begin
        if (srst || !por_s)
        begin
            write_cycle <= 1'b0;
        end
        else if (stop_commit)
        begin
            write_cycle <= 1'b1;                // set wins over clear
        end
        else if (!push_valid && level == '0 && !wr_valid && !array_busy)
        begin
            write_cycle <= 1'b0;
        end
    end

    // standby when idle on the bus with no write cycle running
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            standby <= 1'b0;
        end
        else
        begin
            standby <= (state == ST_STANDBY || state == ST_IGNORE) &&
                       !write_cycle;
        end
    end

endmodule : see_frontend

/* File: core/see_pkg.sv */
// shared constants for the serial eeprom bus slave front end
package see_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and sizes
    localparam int unsigned SEE_ADDR_W = 17;
    localparam int unsigned SEE_DATA_W = 8;
    localparam int unsigned SEE_KIND_W = 2;
    // fifo word: kind, id page flag, address, data
    localparam int unsigned SEE_WORD_W =
        SEE_KIND_W + 1 + SEE_ADDR_W + SEE_DATA_W;
    localparam int unsigned SEE_FIFO_DEPTH = 32;
    // room kept free: one data byte plus its closing marker
    localparam int unsigned SEE_FIFO_SPARE = 2;
    localparam int unsigned SEE_PAGE_BITS = 8;

    ////////////////////////////////////////////////////////////////////////
    // select byte layout, sent msb first
    localparam logic [3:0] SEE_TYPE_ARRAY = 4'hA;
    localparam logic [3:0] SEE_TYPE_IDPAGE = 4'hB;
    localparam int unsigned SEE_SEL_TYPE_HI = 7;
    localparam int unsigned SEE_SEL_TYPE_LO = 4;
    localparam int unsigned SEE_SEL_STRAP_HI = 3;
    localparam int unsigned SEE_SEL_STRAP_LO = 2;
    localparam int unsigned SEE_SEL_TOP_ADDR = 1;
    localparam int unsigned SEE_SEL_RW = 0;
    localparam int unsigned SEE_TOP_ADDR_POS = 16;

    ////////////////////////////////////////////////////////////////////////
    // bit counting within a byte
    localparam logic [3:0] SEE_BITS_PER_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // kinds of fifo word handed to the array
    localparam logic [1:0] SEE_KIND_DATA = 2'h0;
    localparam logic [1:0] SEE_KIND_COMMIT = 2'h1;
    localparam logic [1:0] SEE_KIND_DISCARD = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // protocol engine states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_STANDBY,
        ST_SELECT,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WRITE,
        ST_READ,
        ST_IGNORE
    } see_state_e;

endpackage : see_pkg

/* File: verification/see_bus_master.sv */
`timescale 1ns/10ps
// bus master: makes the 32 ns bus clock only within frames
module see_bus_master
(
    output logic scl,
    output logic m_low,
    input wire logic sda_line
);
    // idle: clock high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        m_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // start or restart; the 1 ns keeps changes off core clock edges
    task start();
        #1;
        m_low = 1'b0;
        #12;
        scl = 1'b1;
        #16;
        m_low = 1'b1;
        #16;
        scl = 1'b0;
        #4;
    endtask : start
    // clock then stays high until the next frame
    task stop();
        m_low = 1'b1;
        #12;
        scl = 1'b1;
        #16;
        m_low = 1'b0;
        #16;
    endtask : stop
    // byte sent msb first, ack read late in the high phase
    task put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            m_low = !b[i];
            #12;
            scl = 1'b1;
            #16;
            scl = 1'b0;
            #4;
        end
        m_low = 1'b0;
        #12;
        scl = 1'b1;
        #15;
        ack = !sda_line;
        #1;
        scl = 1'b0;
        #4;
    endtask : put
    // byte read; the master never acks, ending the read
    task get(output logic [7:0] d);
        m_low = 1'b0;
        for (int i = 8; i >= 0; i--)
        begin
            #12;
            scl = 1'b1;
            #15;
            if (i > 0)
                d[i-1] = sda_line;
            #1;
            scl = 1'b0;
            #4;
        end
    endtask : get
endmodule : see_bus_master

/* File: verification/see_frontend_properties.sv */
`timescale 1ns/10ps
// watches the front end ports only
module see_frontend_properties
    import see_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic por_ok,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic rd_req,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [SEE_KIND_W-1:0] wr_kind,
    input wire logic [SEE_ADDR_W-1:0] wr_addr,
    input wire logic [SEE_DATA_W-1:0] wr_data,
    input wire logic array_busy,
    input wire logic standby,
    input wire logic write_cycle
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // steps: commit handed over, bus clock low long enough to be seen
    sequence seq_commit_taken;
        wr_valid && wr_ready && wr_kind == SEE_KIND_COMMIT;
    endsequence
    sequence seq_scl_fell;
        !$past(scl_in, 2) && !$past(scl_in, 3);
    endsequence
    // five cycles covers the two-flop sync plus the engine register
    sequence seq_por_lost;
        !por_ok [*5];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (
        $fell(srst) |-> !sda_oe && !standby && !wr_valid && !write_cycle)
        else $error("outputs not quiet after reset");
    a_drain_only: assert property (
        sda_out == 1'b0) else $error("data pin driven high");
    a_por_gate: assert property (
        seq_por_lost |-> !sda_oe && !rd_req && !write_cycle)
        else $error("activity without supply");
    a_busy_silent: assert property (
        write_cycle |-> !sda_oe && !standby)
        else $error("pin or standby active in write cycle");
    a_ack_on_low: assert property (
        $changed(sda_oe) |-> seq_scl_fell)
        else $error("data pin changed outside low clock");
    a_rd_single: assert property (
        rd_req |=> !rd_req) else $error("read request too long");
    a_commit_busy: assert property (
        seq_commit_taken |-> write_cycle)
        else $error("commit without write cycle");
    a_word_hold: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)
        && $stable(wr_addr) && $stable(wr_kind))
        else $error("array word changed while stalled");
    a_cycle_hold: assert property (
        write_cycle && por_ok && (wr_valid || array_busy) |=> write_cycle)
        else $error("write cycle ended early");
endmodule : see_frontend_properties

bind see_frontend see_frontend_properties u_see_props (.core_clk, .srst,
    .por_ok, .scl_in, .sda_out, .sda_oe, .rd_req, .wr_valid, .wr_ready,
    .wr_kind, .wr_addr, .wr_data, .array_busy, .standby, .write_cycle);

/* File: verification/serial_eeprom_bus_slave_frontend_test.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    errors++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module serial_eeprom_bus_slave_frontend_test;
    import see_pkg::*;
    logic core_clk = 0, srst = 1, por_ok = 0, write_inhibit_input = 0;
    logic chip_select_strap_high = 1, chip_select_strap_low = 0;
    logic id_page_locked = 0, wr_ready = 1, ack, sda_out, sda_oe, rd_req;
    logic rd_id, wr_valid, wr_id, standby, write_cycle, array_busy;
    logic [16:0] rd_addr, wr_addr;
    logic [7:0] wr_data, rd_data, d;
    logic [1:0] wr_kind;
    logic [26:0] got[$];
    int errors = 0, total_checks = 0, cycles = 0, busy_cnt = 0, ndata = 0;
    wire scl, m_low;
    wire sda_line = !(sda_oe || m_low);

    // array side: busy from the commit word on, data follows address
    assign array_busy = busy_cnt != 0 || (wr_valid && wr_ready
        && wr_kind === SEE_KIND_COMMIT);
    assign rd_data = rd_addr[7:0] ^ 8'h5A;
    always #2 core_clk = ~core_clk;
    see_bus_master m (.scl, .m_low, .sda_line);
    see_frontend #(.HAS_ID_PAGE(1'b1), .FIFO_DEPTH(32)) DUT (.core_clk,
        .srst, .por_ok, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
        .chip_select_strap_low, .chip_select_strap_high,
        .write_inhibit_input, .id_page_locked, .array_busy, .rd_data,
        .rd_req, .rd_id, .rd_addr, .wr_valid, .wr_ready, .wr_kind, .wr_id,
        .wr_addr, .wr_data, .standby, .write_cycle);

    ////////////////////////////////////////////////////////////////////////
    // sink collects words; cycle ceiling cuts a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (wr_valid && wr_ready)
        begin
            got.push_back({wr_kind, wr_addr, wr_data});
            ndata += (wr_kind === SEE_KIND_DATA);
            if (wr_kind === SEE_KIND_COMMIT)
                busy_cnt <= 200;
        end
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
        if (cycles == 40000)
        begin
            errors++;
            results();
        end
    end

    task results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task send(input logic [7:0] b, input logic ex);
        m.put(b, ack);
        `CHK("ack", ex, ack)
    endtask : send
    // bounded wait for the write cycle to finish
    task wait_idle();
        for (int n = 0; n < 3000 && write_cycle !== 1'b0; n++)
            @(negedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (8) @(posedge core_clk);
        `CHK("standby", 1'b0, standby)
        m.start();
        send(8'hA8, 1'b0);
        m.stop();
        @(posedge core_clk);
        por_ok <= 1'b1;
        repeat (8) @(posedge core_clk);
        `CHK("standby", 1'b1, standby)
        // every strap code; only the wired one answers
        for (int s = 0; s < 4; s++)
        begin
            m.start();
            send({4'hA, s[1:0], 2'b00}, s == 2);
            m.stop();
            `CHK("write_cycle", 1'b0, write_cycle)
        end
        // byte write at the top half of the array
        m.start();
        send(8'hAA, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        send(8'h5A, 1'b1);
        m.stop();
        `CHK("write_cycle", 1'b1, write_cycle)
        m.start();
        send(8'hAA, 1'b0);
        m.stop();
        wait_idle();
        `CHK("standby", 1'b1, standby)
        `CHK("word", {SEE_KIND_DATA, 17'h11234, 8'h5A}, got[0])
        `CHK("kind", SEE_KIND_COMMIT, got[1][26:25])
        // inhibit: header acked, data refused and not queued
        write_inhibit_input <= 1'b1;
        ndata = 0;
        m.start();
        send(8'hA8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h10, 1'b1);
        send(8'h77, 1'b0);
        m.stop();
        wait_idle();
        `CHK("data words", 0, ndata)
        write_inhibit_input <= 1'b0;
        // random read through a restart
        m.start();
        send(8'hA8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h77, 1'b1);
        m.start();
        send(8'hA9, 1'b1);
        m.get(d);
        m.stop();
        `CHK("read", 8'h2D, d)
        // stalled array: buffer fills until data bytes are refused
        got.delete();
        @(posedge core_clk) wr_ready <= 1'b0;
        m.start();
        send(8'hA8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h00, 1'b1);
        for (int i = 0; i < 34; i++)
        begin
            m.put(i[7:0], ack);
            if (i < 30 || i >= 32)
                `CHK("fill ack", i < 30, ack)
        end
        m.stop();
        @(posedge core_clk);
        wr_ready <= 1'b1;
        repeat (40) @(posedge core_clk);
        `CHK("last word", {17'h0001D, 8'h1D}, got[29][24:0])
        `CHK("write_cycle", 1'b0, write_cycle)
        // supply lost: no answer
        por_ok <= 1'b0;
        repeat (8) @(posedge core_clk);
        m.start();
        send(8'hA8, 1'b0);
        m.stop();
        results();
    end
endmodule : serial_eeprom_bus_slave_frontend_test
